// [hdl/basic_upcount_timer.sv]
// basic_upcount_timer: 16-bit prescaled up-counter with auto-reload,
// update event, sticky update flag, interrupt and dma request.
// assumes mclk is the internal timer clock and debug_halt_stop comes
// from a foreign domain (debug block) and is synchronised here.
//
// How it works
// - sixteen-bit up-only counter reloading automatically at the auto-reload value
// - prescaler divides by stored value plus one, ratios 1 to 65536
// - prescaler writes are buffered, taking effect at the next update event
// - reload writes reach shadow at once without preload, else at update
// - overflow or software update makes an update event, only if not disabled
// - counter clock runs only when enabled, starting one cycle after enabling
// - counter steps zero to reload value, wraps to zero with overflow
// - software update with source select set does not set the flag
// - qualifying update sets flag, loads prescaler and preloaded reload shadows
// - while update disabled, the prescaler and preloaded reload buffers do not reach the shadows
// - update clears counter and prescaler count, keeps the division value
// - once enabled, the prescaler is clocked from the internal timer clock
// - prescaler, counter and reload registers are accessible at any time
// - interrupt and dma requests come only from the update event
// - a zero auto-reload value stops the counter
// - during debug halt the counter freezes when the stop bit is set
`timescale 1ns/1ps
`default_nettype none

module basic_upcount_timer (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire logic debug_halt,
	input wire logic debug_halt_stop,
	output logic irq,
	output logic dma_req
);

	// ********************************************************************
	// bus slave: one wait cycle per access, answer on the second edge
	// ********************************************************************
	logic ack_reg;
	logic access;
	logic wr_hit;
	logic lo_en;

	assign access = (read || write) && !ack_reg;
	// a write lands on the edge at which the master sees waitrequest low
	assign wr_hit = write && ack_reg;
	assign lo_en = byteenable[0] || byteenable[1];

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ack_reg <= 1'b0;
			waitrequest <= 1'b1;
		end else begin
			ack_reg <= access;
			waitrequest <= !access;
		end
	end

	// ********************************************************************
	// debug halt inputs: two-stage synchronisers
	// ********************************************************************
	logic [1:0] halt_sync_reg;
	logic [1:0] stop_sync_reg;
	logic frozen;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			halt_sync_reg <= 2'b00;
			stop_sync_reg <= 2'b00;
		end else begin
			halt_sync_reg <= {halt_sync_reg[0], debug_halt};
			stop_sync_reg <= {stop_sync_reg[0], debug_halt_stop};
		end
	end

	assign frozen = halt_sync_reg[1] && stop_sync_reg[1];

	// ********************************************************************
	// control and enables
	// ********************************************************************
	timer_pkg::ctrl_t ctrl_reg;
	timer_pkg::enable_t enable_reg;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= '0;
		end else if (wr_hit && address == timer_pkg::ctrl_off && byteenable[0]) begin
			ctrl_reg.count_enable_bit <=
				writedata[timer_pkg::count_enable_pos];
			ctrl_reg.update_disable <= writedata[timer_pkg::update_disable_pos];
			ctrl_reg.update_request_source_select <=
				writedata[timer_pkg::update_source_pos];
			ctrl_reg.reload_preload_enable <=
				writedata[timer_pkg::reload_preload_pos];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			enable_reg <= '0;
		end else if (wr_hit && address == timer_pkg::int_enable_off && lo_en) begin
			enable_reg.irq_enable <= writedata[timer_pkg::update_ie_pos];
			enable_reg.dma_enable <= writedata[timer_pkg::update_de_pos];
		end
	end

	// ********************************************************************
	// update event generation
	// ********************************************************************
	logic [15:0] count_reg;
	logic [15:0] presc_count_reg;
	logic [15:0] presc_buf_reg;
	logic [15:0] presc_shadow_reg;
	logic [15:0] reload_buf_reg;
	logic [15:0] reload_shadow_reg;
	logic sw_update_reg;
	logic update_flag_reg;
	logic tick;
	logic overflow;
	logic update_event;
	logic flag_set;
	logic cnt_wr;
	logic running;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			sw_update_reg <= 1'b0;
		end else begin
			sw_update_reg <= wr_hit && address == timer_pkg::event_gen_off &&
				byteenable[0] && writedata[timer_pkg::sw_update_pos];
		end
	end

	assign running = ctrl_reg.count_enable_bit && !frozen &&
		reload_shadow_reg != 16'h0000;
	assign tick = running && presc_count_reg >= presc_shadow_reg;
	assign overflow = tick && count_reg >= reload_shadow_reg;
	assign update_event = !ctrl_reg.update_disable &&
		(overflow || sw_update_reg);
	assign flag_set = !ctrl_reg.update_disable && (overflow ||
		(sw_update_reg && !ctrl_reg.update_request_source_select));
	assign cnt_wr = wr_hit && address == timer_pkg::counter_off && lo_en;

	// ********************************************************************
	// prescaler and counter
	// ********************************************************************
	// clear on update
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			presc_count_reg <= 16'h0000;
		end else if (update_event || tick) begin
			presc_count_reg <= 16'h0000;
		end else if (running) begin
			presc_count_reg <= presc_count_reg + 16'h0001;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			count_reg <= timer_pkg::counter_reset;
		end else if (update_event || (overflow && ctrl_reg.update_disable)) begin
			count_reg <= 16'h0000;
		end else if (cnt_wr) begin
			count_reg <= writedata[15:0];
		end else if (tick) begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	// ********************************************************************
	// buffered settings
	// ********************************************************************
	// prescaler buffer
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			presc_buf_reg <= timer_pkg::prescaler_reset;
		end else if (wr_hit && address == timer_pkg::prescaler_off && lo_en) begin
			presc_buf_reg <= writedata[15:0];
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			presc_shadow_reg <= timer_pkg::prescaler_reset;
		end else if (update_event) begin
			presc_shadow_reg <= presc_buf_reg;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reload_buf_reg <= timer_pkg::reload_reset;
		end else if (wr_hit && address == timer_pkg::reload_off && lo_en) begin
			reload_buf_reg <= writedata[15:0];
		end
	end

	// reload shadow
	// without preload the shadow tracks the buffer on every cycle
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			reload_shadow_reg <= timer_pkg::reload_reset;
		end else if (!ctrl_reg.reload_preload_enable) begin
			reload_shadow_reg <= reload_buf_reg;
		end else if (update_event) begin
			reload_shadow_reg <= reload_buf_reg;
		end
	end

	// ********************************************************************
	// status flag, interrupt and dma request
	// ********************************************************************
	// sticky flag, set beats clear
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			update_flag_reg <= 1'b0;
		end else if (flag_set) begin
			update_flag_reg <= 1'b1;
		end else if (wr_hit && address == timer_pkg::status_off &&
			byteenable[0] && writedata[timer_pkg::update_flag_pos]) begin
			update_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
			dma_req <= 1'b0;
		end else begin
			irq <= (update_flag_reg || flag_set) && enable_reg.irq_enable;
			dma_req <= flag_set && enable_reg.dma_enable;
		end
	end

	// ********************************************************************
	// read data
	// ********************************************************************
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			readdata <= timer_pkg::unmapped_read;
		end else if (access && read) begin
			if (address == timer_pkg::ctrl_off) begin
				readdata <= {24'h000000, ctrl_reg.reload_preload_enable, 4'h0,
					ctrl_reg.update_request_source_select,
					ctrl_reg.update_disable, ctrl_reg.count_enable_bit};
			end else if (address == timer_pkg::int_enable_off) begin
				readdata <= {23'h000000, enable_reg.dma_enable, 7'h00,
					enable_reg.irq_enable};
			end else if (address == timer_pkg::status_off) begin
				readdata <= {31'h00000000, update_flag_reg};
			end else if (address == timer_pkg::counter_off) begin
				readdata <= {16'h0000, count_reg};
			end else if (address == timer_pkg::prescaler_off) begin
				readdata <= {16'h0000, presc_buf_reg};
			end else if (address == timer_pkg::reload_off) begin
				readdata <= {16'h0000, reload_buf_reg};
			end else begin
				readdata <= timer_pkg::unmapped_read;
			end
		end
	end

	// ********************************************************************
	// checks
	// ********************************************************************
	a_wrap_to_zero: assert property (@(posedge mclk) disable iff (!reset_n)
		overflow && !cnt_wr |=> count_reg == 16'h0000)
		else $error("counter did not wrap to zero");
	a_zero_reload_stops: assert property (@(posedge mclk) disable iff (!reset_n)
		reload_shadow_reg == 16'h0000 && !sw_update_reg && !cnt_wr
		|=> $stable(count_reg))
		else $error("counter moved with zero reload");
	a_disabled_holds: assert property (@(posedge mclk) disable iff (!reset_n)
		!ctrl_reg.count_enable_bit && !sw_update_reg && !cnt_wr
		|=> $stable(count_reg))
		else $error("counter moved while disabled");
	a_quiet_source: assert property (@(posedge mclk) disable iff (!reset_n)
		sw_update_reg && !overflow && ctrl_reg.update_request_source_select
		&& !update_flag_reg |=> !update_flag_reg)
		else $error("quiet update set the flag");
	a_flag_on_overflow: assert property (@(posedge mclk) disable iff (!reset_n)
		overflow && !ctrl_reg.update_disable |=> update_flag_reg)
		else $error("overflow did not set flag");
	a_no_update_disabled: assert property (@(posedge mclk) disable iff (!reset_n)
		ctrl_reg.update_disable |=> $stable(presc_shadow_reg))
		else $error("shadow loaded while updates disabled");
	a_presc_clear: assert property (@(posedge mclk) disable iff (!reset_n)
		update_event |=> presc_count_reg == 16'h0000 &&
		presc_shadow_reg == $past(presc_buf_reg))
		else $error("prescaler not reset on update");
	a_irq_gated: assert property (@(posedge mclk) disable iff (!reset_n)
		irq |-> $past(enable_reg.irq_enable))
		else $error("interrupt without enable");
	a_dma_source: assert property (@(posedge mclk) disable iff (!reset_n)
		dma_req |-> $past(flag_set))
		else $error("dma request without update");
	a_flag_sticky: assert property (@(posedge mclk) disable iff (!reset_n)
		update_flag_reg && !wr_hit |=> update_flag_reg)
		else $error("flag dropped without software");
	a_update_clears: assert property (
		@(posedge mclk) disable iff (!reset_n)
		update_event |=> count_reg == 16'h0000)
		else $error("update did not clear counter");
	a_count_steps: assert property (
		@(posedge mclk) disable iff (!reset_n)
		tick && !overflow && !update_event && !cnt_wr
		|=> count_reg == $past(count_reg) + 16'h0001)
		else $error("counter did not step by one");
	a_presc_steps: assert property (
		@(posedge mclk) disable iff (!reset_n)
		running && !tick && !update_event
		|=> presc_count_reg == $past(presc_count_reg) + 16'h0001)
		else $error("prescaler count did not step");
	a_reload_direct: assert property (
		@(posedge mclk) disable iff (!reset_n)
		!ctrl_reg.reload_preload_enable
		|=> reload_shadow_reg == $past(reload_buf_reg))
		else $error("reload shadow did not follow buffer");
	a_reload_held: assert property (
		@(posedge mclk) disable iff (!reset_n)
		ctrl_reg.reload_preload_enable && !update_event
		|=> $stable(reload_shadow_reg))
		else $error("preloaded reload shadow moved early");
	a_sw_update_clear: assert property (
		@(posedge mclk) disable iff (!reset_n)
		sw_update_reg |=> !sw_update_reg)
		else $error("software update request stuck");
	a_count_hold_frozen: assert property (
		@(posedge mclk) disable iff (!reset_n)
		frozen && !sw_update_reg && !cnt_wr |=> $stable(count_reg))
		else $error("counter moved while frozen");

endmodule

`default_nettype wire

// [include/timer_pkg.sv]
// timer_pkg: register map, field positions and reset values of the basic
// up-count timer. assumes a 32-bit avalon-mm slave with word addressing
// in bytes; registers hold 16 bits in the low half.
package timer_pkg;

	// ********************************************************************
	// register offsets (byte addresses)
	// ********************************************************************
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] int_enable_off = 8'h0C;
	localparam logic [7:0] status_off = 8'h10;
	localparam logic [7:0] event_gen_off = 8'h14;
	localparam logic [7:0] counter_off = 8'h24;
	localparam logic [7:0] prescaler_off = 8'h28;
	localparam logic [7:0] reload_off = 8'h2C;

	// ********************************************************************
	// field positions
	// ********************************************************************
	localparam int count_enable_pos = 0;
	localparam int update_disable_pos = 1;
	localparam int update_source_pos = 2;
	localparam int reload_preload_pos = 7;
	localparam int update_ie_pos = 0;
	localparam int update_de_pos = 8;
	localparam int update_flag_pos = 0;
	localparam int sw_update_pos = 0;

	// ********************************************************************
	// reset values
	// ********************************************************************
	localparam logic [15:0] reload_reset = 16'hFFFF;
	localparam logic [15:0] prescaler_reset = 16'h0000;
	localparam logic [15:0] counter_reset = 16'h0000;
	localparam logic [31:0] unmapped_read = 32'h0000_0000;

	typedef struct packed {
		logic reload_preload_enable;
		logic update_request_source_select;
		logic update_disable;
		logic count_enable_bit;
	} ctrl_t;

	typedef struct packed {
		logic irq_enable;
		logic dma_enable;
	} enable_t;

endpackage

// [verification/tb_basic_upcount_timer.sv]
// tb_basic_upcount_timer: self-checking bench for the up-count timer.
// assumes the avalon slave answers after one wait cycle and that dma_req
// pulses once for every update that sets the update flag.
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
	num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); \
	end end

module tb_basic_upcount_timer;
	logic mclk, reset_n, read, write, debug_halt, debug_halt_stop;
	logic [7:0] address;
	logic [31:0] writedata, readdata;
	logic [3:0] byteenable;
	logic waitrequest, irq, dma_req;
	logic [31:0] exp_q[$];
	logic [31:0] exp_word;
	int num_errors = 0;
	int checks = 0;
	int gap = 0;
	int last_gap = 0;
	int pulses = 0;
	int p, q, g, n;

	basic_upcount_timer i_basic_upcount_timer (.mclk(mclk),
		.reset_n(reset_n), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest),
		.debug_halt(debug_halt), .debug_halt_stop(debug_halt_stop),
		.irq(irq), .dma_req(dma_req));

	// ****************************************************************
	// clock, watchdog and output watchers
	// ****************************************************************
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// span covers the longest gaps (psc up to 3) with ample margin
	initial begin
		repeat (30000) @(posedge mclk);
		num_errors++;
		tally_and_finish();
	end

	always @(posedge mclk) begin
		if (read === 1'b1 && waitrequest === 1'b0 && exp_q.size() > 0) begin
			exp_word = exp_q.pop_front();
			`CHK(readdata, exp_word) // read data
		end
	end

	// cycles between consecutive dma pulses give the update period
	always @(posedge mclk) begin
		if (dma_req === 1'b1) begin
			last_gap <= gap;
			gap <= 1;
			pulses <= pulses + 1;
		end else begin
			gap <= gap + 1;
		end
	end

	// ****************************************************************
	// bus and helper tasks
	// ****************************************************************
	task automatic wait_ack();
		do begin
			@(posedge mclk);
		end while (waitrequest !== 1'b0);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		address <= a;
		writedata <= d;
		write <= 1'b1;
		wait_ack();
		write <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		@(posedge mclk);
		address <= a;
		read <= 1'b1;
		wait_ack();
		read <= 1'b0;
	endtask

	task automatic next_gap(output int r);
		int k, m;
		k = 0;
		m = pulses;
		while (pulses == m && k < 3000) begin
			@(posedge mclk);
			#1;
			k++;
		end
		if (k >= 3000) num_errors++;
		r = last_gap;
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask

	task automatic tally_and_finish();
		$display("checks %0d, num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		reset_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0;
		byteenable = 4'hF;
		debug_halt = 1'b0;
		debug_halt_stop = 1'b0;
		void'($urandom(32'hB3A332E9));
		p = $urandom_range(3, 0);
		q = $urandom_range(3, 0);
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		rd(timer_pkg::reload_off, 32'h0000FFFF); // reload reset
		rd(timer_pkg::prescaler_off, 32'h0); // prescaler reset
		rd(timer_pkg::counter_off, 32'h0); // counter reset
		rd(timer_pkg::status_off, 32'h0); // flag clear
		rd(8'h30, 32'h0); // unmapped read
		wr(8'h30, 32'hFFFF);
		rd(8'h30, 32'h0); // unmapped write
		@(posedge mclk);
		byteenable <= 4'hC;
		wr(timer_pkg::counter_off, 32'h5678);
		byteenable <= 4'hF;
		rd(timer_pkg::counter_off, 32'h0); // byte lanes
		// stopped timer: counter access and update gating
		wr(timer_pkg::counter_off, 32'h1234);
		rd(timer_pkg::counter_off, 32'h1234); // counter write
		wr(timer_pkg::ctrl_off, 32'h2);
		wr(timer_pkg::event_gen_off, 32'h1);
		rd(timer_pkg::event_gen_off, 32'h0); // event register reads as unmapped zero
		rd(timer_pkg::counter_off, 32'h1234); // update blocked
		rd(timer_pkg::status_off, 32'h0); // no update
		wr(timer_pkg::ctrl_off, 32'h0);
		wr(timer_pkg::event_gen_off, 32'h1);
		rd(timer_pkg::counter_off, 32'h0); // counter cleared
		rd(timer_pkg::status_off, 32'h1); // flag set
		`CHK(irq, 1'b0) // irq masked
		wr(timer_pkg::int_enable_off, 32'h1);
		settle(3);
		`CHK(irq, 1'b1) // irq raised
		wr(timer_pkg::status_off, 32'h1);
		rd(timer_pkg::status_off, 32'h0); // flag cleared
		settle(2);
		`CHK(irq, 1'b0) // irq dropped
		wr(timer_pkg::int_enable_off, 32'h101);
		wr(timer_pkg::ctrl_off, 32'h4);
		n = pulses;
		wr(timer_pkg::event_gen_off, 32'h1);
		settle(4);
		`CHK(irq, 1'b0) // no interrupt
		rd(timer_pkg::status_off, 32'h0); // flag suppressed
		`CHK(pulses, n) // no dma
		// running timer: periods and buffering
		wr(timer_pkg::ctrl_off, 32'h0);
		wr(timer_pkg::reload_off, 32'd99);
		wr(timer_pkg::prescaler_off, p);
		wr(timer_pkg::event_gen_off, 32'h1);
		wr(timer_pkg::int_enable_off, 32'h101);
		wr(timer_pkg::ctrl_off, 32'h1);
		next_gap(g);
		next_gap(g);
		`CHK(g, (p + 1) * 100) // division ratio
		`CHK(irq, 1'b1) // update irq
		wr(timer_pkg::prescaler_off, q);
		next_gap(g);
		`CHK(g, (p + 1) * 100) // prescaler deferred
		next_gap(g);
		`CHK(g, (q + 1) * 100) // prescaler loaded
		wr(timer_pkg::ctrl_off, 32'h81);
		wr(timer_pkg::reload_off, 32'd39);
		rd(timer_pkg::reload_off, 32'd39); // reload readback
		next_gap(g);
		`CHK(g, (q + 1) * 100) // reload deferred
		next_gap(g);
		`CHK(g, (q + 1) * 40) // new wrap point
		// debug halt freezes or keeps running
		@(posedge mclk);
		debug_halt <= 1'b1;
		debug_halt_stop <= 1'b1;
		settle(4);
		n = pulses;
		settle(400);
		`CHK(pulses, n) // frozen
		@(posedge mclk);
		debug_halt_stop <= 1'b0;
		next_gap(g);
		next_gap(g);
		`CHK(g, (q + 1) * 40) // keeps running
		@(posedge mclk);
		debug_halt <= 1'b0;
		// zero reload value stops counting
		wr(timer_pkg::ctrl_off, 32'h0);
		wr(timer_pkg::reload_off, 32'h0);
		wr(timer_pkg::event_gen_off, 32'h1);
		wr(timer_pkg::ctrl_off, 32'h1);
		settle(4);
		n = pulses;
		settle(300);
		`CHK(pulses, n) // no overflow
		rd(timer_pkg::counter_off, 32'h0); // counter idle
		settle(2);
		tally_and_finish();
	end
endmodule

`undef CHK
`default_nettype wire
